// ### qdsc_top.sv
// Serial interface and control of the quad converter
`timescale 1ns/1ps
`include "qdsc_consts.svh"
module qdsc_top #(
    parameter int DATA_W = `QDSC_DATA_W,
    parameter int NCH    = `QDSC_NCH
) (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // Serial link
    input  wire logic        CS_N,
    input  wire logic        SCLK,
    input  wire logic        SERIAL_IN,
    output logic             SDO,
    output logic             SDO_OE,
    // Update and supply monitor
    input  wire logic        ASYNC_LOAD_N,
    input  wire logic        PWR_LOST,
    output logic             PFAIL_N,
    // Converter codes
    output logic [4*8-1:0]   DAC_CODE
);
    generate
        if (DATA_W != 8 || NCH != 4)
        begin : g_bad
            $error("qdsc_top serves only four 8-bit channels");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    localparam qdsc_pkg::qdsc_ctl_t RST_VAL = '{
        st: qdsc_pkg::QDSC_IDLE, sclk_q: 1'b0, cs_q: 1'b1, au_q: 1'b1,
        first: 1'b1, icnt: 3'h0, bcnt: 3'h0, rw: 1'b0, glob: 1'b0,
        flag: 1'b0, msb: 1'b0, a_hi: 1'b0, ch: `QDSC_CH_FIRST,
        wdat: `QDSC_CODE_RESET, wr_en: 1'b0, wr_addr: 2'h0,
        wr_data: `QDSC_CODE_RESET, skip: 1'b0, upd: 4'h0,
        dac: {4{`QDSC_CODE_RESET}}, sdo: 1'b0, oe: 1'b0, pfail_n: 1'b1};

    qdsc_pkg::qdsc_ctl_t s_r;
    qdsc_pkg::qdsc_ctl_t s_nxt;
    qdsc_mem_if          mem ();
    logic                rise;
    logic                fall;
    logic                out_edge;

    function automatic logic pick_bit(input qdsc_pkg::qdsc_byte_t b,
                                      input logic [2:0] idx,
                                      input logic msb_first);
        logic [2:0] i;
        i = msb_first ? (`QDSC_BYTE_LAST - idx) : idx;
        return b[i];
    endfunction

    qdsc_inbank u_bank (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .bus   (mem)
    );

    assign mem.wr_en   = s_r.wr_en;
    assign mem.wr_addr = s_r.wr_addr;
    assign mem.wr_data = s_r.wr_data;
    assign mem.rd_addr = s_r.ch;

    assign rise     = SCLK && !s_r.sclk_q;
    assign fall     = !SCLK && s_r.sclk_q;
    assign out_edge = s_r.flag ? rise : fall;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.sclk_q = SCLK;
        s_nxt.cs_q   = CS_N;
        s_nxt.au_q   = ASYNC_LOAD_N;
        s_nxt.first  = 1'b0;
        s_nxt.wr_en  = 1'b0;
        // Power-fail flag; catching a failure wins over release
        if (s_r.first && PWR_LOST)
            s_nxt.pfail_n = 1'b0;
        else if (!CS_N)
            s_nxt.pfail_n = 1'b1;
        if (CS_N)
        begin
            s_nxt.st   = qdsc_pkg::QDSC_IDLE;
            s_nxt.oe   = 1'b0;
            s_nxt.icnt = 3'h0;
            s_nxt.bcnt = 3'h0;
            if (!s_r.cs_q)
            begin
                for (int i = 0; i < 4; i++)
                begin
                    if (s_r.upd[i])
                        s_nxt.dac[i] = mem.all_data[i];
                end
                s_nxt.upd = 4'h0;
            end
            else if (s_r.au_q && !ASYNC_LOAD_N)
            begin
                s_nxt.dac = mem.all_data;
            end
        end
        else
        begin
            case (s_r.st)
                qdsc_pkg::QDSC_IDLE:
                begin
                    if (rise && SERIAL_IN)
                    begin
                        s_nxt.st   = qdsc_pkg::QDSC_INSTR;
                        s_nxt.icnt = 3'h1;
                    end
                end
                qdsc_pkg::QDSC_INSTR:
                begin
                    if (rise)
                    begin
                        s_nxt.icnt = s_r.icnt + 3'h1;
                        case (s_r.icnt)
                            3'h1: s_nxt.rw = SERIAL_IN;
                            3'h2: s_nxt.glob = SERIAL_IN;
                            3'h3: s_nxt.flag = SERIAL_IN;
                            3'h4:
                            begin
                                if (s_r.rw)
                                    s_nxt.msb = SERIAL_IN;
                                else
                                    s_nxt.a_hi = SERIAL_IN;
                            end
                            3'h5: s_nxt.a_hi = SERIAL_IN;
                            default: s_nxt.a_hi = s_r.a_hi;
                        endcase
                        if (!s_r.rw && s_r.glob
                            && s_r.icnt == `QDSC_HDR_BROAD)
                        begin
                            s_nxt.st   = qdsc_pkg::QDSC_WDATA;
                            s_nxt.ch   = `QDSC_CH_FIRST;
                            // Bit four is the load flag, not data
                            s_nxt.wdat = `QDSC_CODE_RESET;
                            s_nxt.bcnt = 3'h0;
                        end
                        else if (!s_r.rw
                                 && s_r.icnt == `QDSC_HDR_WSINGLE)
                        begin
                            s_nxt.st   = qdsc_pkg::QDSC_WDATA;
                            s_nxt.ch   = {s_r.a_hi, SERIAL_IN};
                            s_nxt.bcnt = 3'h0;
                        end
                        else if (s_r.rw && s_r.icnt == `QDSC_HDR_READ)
                        begin
                            s_nxt.st   = qdsc_pkg::QDSC_RDATA;
                            s_nxt.ch   = (s_r.glob
                                && {s_r.a_hi, SERIAL_IN}
                                   == `QDSC_RD_ALL_ADDR)
                                ? `QDSC_CH_FIRST
                                : {s_r.a_hi, SERIAL_IN};
                            s_nxt.glob = s_r.glob
                                && {s_r.a_hi, SERIAL_IN}
                                   == `QDSC_RD_ALL_ADDR;
                            s_nxt.skip = 1'b1;
                            s_nxt.bcnt = 3'h0;
                        end
                    end
                end
                qdsc_pkg::QDSC_WDATA:
                begin
                    if (rise)
                    begin
                        s_nxt.wdat[s_r.bcnt] = SERIAL_IN;
                        s_nxt.bcnt = s_r.bcnt + 3'h1;
                        if (s_r.bcnt == `QDSC_BYTE_LAST)
                        begin
                            s_nxt.wr_en   = 1'b1;
                            s_nxt.wr_addr = s_r.ch;
                            s_nxt.wr_data = {SERIAL_IN, s_r.wdat[6:0]};
                            s_nxt.upd[s_r.ch] = s_r.upd[s_r.ch]
                                                | s_r.flag;
                            if (s_r.glob && s_r.ch != `QDSC_CH_LAST)
                                s_nxt.ch = s_r.ch + 2'h1;
                            else
                                s_nxt.st = qdsc_pkg::QDSC_DONE;
                        end
                    end
                end
                qdsc_pkg::QDSC_RDATA:
                begin
                    if (out_edge && s_r.skip)
                    begin
                        s_nxt.skip = 1'b0;
                    end
                    else if (out_edge)
                    begin
                        s_nxt.oe   = 1'b1;
                        s_nxt.sdo  = pick_bit(mem.rd_data, s_r.bcnt,
                                              s_r.msb);
                        s_nxt.bcnt = s_r.bcnt + 3'h1;
                        if (s_r.bcnt == `QDSC_BYTE_LAST)
                        begin
                            if (s_r.glob && s_r.ch != `QDSC_CH_LAST)
                                s_nxt.ch = s_r.ch + 2'h1;
                            else
                                s_nxt.st = qdsc_pkg::QDSC_DONE;
                        end
                    end
                end
                default:
                begin
                    s_nxt.st = qdsc_pkg::QDSC_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
            s_r <= RST_VAL;
        else
            s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    assign SDO      = s_r.sdo;
    assign SDO_OE   = s_r.oe;
    assign PFAIL_N  = s_r.pfail_n;
    assign DAC_CODE = s_r.dac;
endmodule

// ### qdsc_consts.svh
// Constants of the quad converter serial control block
// Notes on behaviour
// - Each channel keeps an 8-bit input register and output register; one shifter serves all.
// - Instruction bits arrive first, then data; decode precedes data.
// - Input is ignored until a high start bit is sampled.
// - Second bit low selects write, high selects readback.
// - Single write uses bits 5 and 6 as channel address 00..11.
// - Write data bytes always arrive least significant bit first.
// - Broadcast write takes four bytes loading channels 1 to 4.
// - Broadcast write header has four bits; data follows at once.
// - Load flag high copies addressed inputs to outputs on select release.
// - Readback returns one channel or all four starting with channel 1.
// - Edge select high: output changes on rising edges, 1.5 cycles late.
// - Edge select low: output changes on falling edges, one cycle late.
// - Bit-order select chooses MSB first when high, LSB first when low.
// - Readback header has seven bits; read-all uses address 10.
// - Falling asynchronous load copies all four input registers to outputs only while select is high.
// - Power-up clears every output register to zero.
// - Power-fail flag driven low after a failure seen in the first cycle out of reset, released on select low.
`ifndef QDSC_CONSTS_SVH
`define QDSC_CONSTS_SVH
`define QDSC_DATA_W        8
`define QDSC_NCH           4
`define QDSC_BYTE_LAST     3'h7
`define QDSC_HDR_BROAD     3'h3
`define QDSC_HDR_WSINGLE   3'h5
`define QDSC_HDR_READ      3'h6
`define QDSC_CH_FIRST      2'h0
`define QDSC_CH_LAST       2'h3
`define QDSC_RD_ALL_ADDR   2'h2
`define QDSC_CODE_RESET    8'h00
`endif

// ### qdsc_pkg.sv
// Types of the quad converter serial control block
package qdsc_pkg;
    typedef logic [7:0] qdsc_byte_t;
    typedef logic [3:0][7:0] qdsc_bank_t;
    typedef enum logic [2:0] {QDSC_IDLE, QDSC_INSTR, QDSC_WDATA,
                              QDSC_RDATA, QDSC_DONE} qdsc_state_t;
    typedef struct packed {
        qdsc_state_t st;
        logic        sclk_q;
        logic        cs_q;
        logic        au_q;
        logic        first;
        logic [2:0]  icnt;
        logic [2:0]  bcnt;
        logic        rw;
        logic        glob;
        logic        flag;
        logic        msb;
        logic        a_hi;
        logic [1:0]  ch;
        qdsc_byte_t  wdat;
        logic        wr_en;
        logic [1:0]  wr_addr;
        qdsc_byte_t  wr_data;
        logic        skip;
        logic [3:0]  upd;
        qdsc_bank_t  dac;
        logic        sdo;
        logic        oe;
        logic        pfail_n;
    } qdsc_ctl_t;
    typedef struct packed {
        qdsc_bank_t  regs;
        qdsc_byte_t  rd;
    } qdsc_mem_t;
endpackage

// ### qdsc_mem_if.sv
// Link between the control logic and the input register bank
`timescale 1ns/1ps
interface qdsc_mem_if;
    logic                wr_en;
    logic [1:0]          wr_addr;
    qdsc_pkg::qdsc_byte_t wr_data;
    logic [1:0]          rd_addr;
    qdsc_pkg::qdsc_byte_t rd_data;
    qdsc_pkg::qdsc_bank_t all_data;
    modport ctl (output wr_en, wr_addr, wr_data, rd_addr,
                 input rd_data, all_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_addr,
                 output rd_data, all_data);
endinterface

// ### qdsc_inbank.sv
// Input register bank with registered read port
`timescale 1ns/1ps
`include "qdsc_consts.svh"
module qdsc_inbank (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Access port
    qdsc_mem_if.mem   bus
);
    qdsc_pkg::qdsc_mem_t s_r;
    qdsc_pkg::qdsc_mem_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (bus.wr_en)
        begin
            s_nxt.regs[bus.wr_addr] = bus.wr_data;
        end
        s_nxt.rd = s_r.regs[bus.rd_addr];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign bus.rd_data  = s_r.rd;
    assign bus.all_data = s_r.regs;
endmodule

// ### qdsc_top_sva.sv
// Assertion checker for the quad converter serial control ports
`timescale 1ns/1ps
module qdsc_top_sva #(
    parameter int DATA_W = 8,
    parameter int NCH    = 4
) (
    // Clock and reset
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    // Serial link
    input wire logic        CS_N,
    input wire logic        SCLK,
    input wire logic        SDO,
    input wire logic        SDO_OE,
    // Update, monitor and codes
    input wire logic        ASYNC_LOAD_N,
    input wire logic        PWR_LOST,
    input wire logic        PFAIL_N,
    input wire logic [31:0] DAC_CODE
);
    default clocking dc @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    sequence s_deselected;
        CS_N [*4];
    endsequence
    sequence s_no_async_fall;
        ASYNC_LOAD_N [*3];
    endsequence
    ////////////////////////////////////////////////////////////////////
    a_reset_clear: assert property (disable iff (1'b0)
        !RST_N |=> DAC_CODE == 32'h0 && !SDO_OE && PFAIL_N)
        else $error("outputs not cleared by reset");
    a_codes_frame: assert property (!CS_N [*4] |-> $stable(DAC_CODE))
        else $error("codes changed inside a frame");
    a_codes_idle: assert property (
        s_deselected ##0 s_no_async_fall |-> $stable(DAC_CODE))
        else $error("codes changed without a load cause");
    a_oe_released: assert property (s_deselected |-> !SDO_OE)
        else $error("output driven while deselected");
    a_oe_selected: assert property ($rose(SDO_OE) |-> !$past(CS_N))
        else $error("output enabled without select");
    a_sdo_clk_edge: assert property (
        SDO_OE && $past(SDO_OE) && $changed(SDO) |->
        $past(SCLK) != $past(SCLK, 2) || $past(SCLK, 2) != $past(SCLK, 3))
        else $error("read data moved off a serial clock edge");
    a_pfail_set: assert property (
        $rose(RST_N) ##1 (PWR_LOST && CS_N) |-> ##[1:2] !PFAIL_N)
        else $error("power fail flag not raised");
    a_pfail_clear: assert property (!CS_N [*4] |=> PFAIL_N)
        else $error("power fail flag not released");
endmodule
bind qdsc_top qdsc_top_sva #(.DATA_W(DATA_W), .NCH(NCH)) qdsc_top_sva_i (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CS_N(CS_N), .SCLK(SCLK),
    .SDO(SDO), .SDO_OE(SDO_OE), .ASYNC_LOAD_N(ASYNC_LOAD_N),
    .PWR_LOST(PWR_LOST), .PFAIL_N(PFAIL_N), .DAC_CODE(DAC_CODE));

// ### qdsc_host.sv
// Host controller model driving the serial link
`timescale 1ns/1ps
module qdsc_host (
    // Clock
    input  wire logic clk,
    // Serial link
    output logic      cs_n,
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end
    // One serial cycle, five ticks low then five high; smp picks a phase
    task automatic tick(input logic b, input int smp, output logic s);
        @(posedge clk);
        sclk <= 1'b0;
        sdi  <= b;
        repeat (4) @(posedge clk);
        if (smp == 0) s = sdo_oe ? sdo : 1'bx;
        @(posedge clk);
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        if (smp == 1) s = sdo_oe ? sdo : 1'bx;
    endtask
    task automatic frame(input logic [63:0] bv, input int n, input int rn,
                         input int edg, output logic [31:0] rd);
        logic s;
        rd = '0;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 0; i < n; i++) tick(bv[i], 2, s);
        for (int c = 1; c <= rn + 1; c++)
        begin
            tick(1'b0, c > 1 ? edg : 2, s);
            if (c > 1) rd[c - 2] = s;
        end
        @(posedge clk);
        sclk <= 1'b0;
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
        sdi  <= ~sdi;
        repeat (5) @(posedge clk);
    endtask
endmodule

// ### qdsc_top_bench.sv
// Self-checking bench for the quad converter serial control
`timescale 1ns/1ps
module qdsc_top_bench;
    logic        clk_sys, rst_n, sdo, sdo_oe, async_load_n, pwr_lost, pfail_n;
    logic        cs_n, sclk, serial_in;
    logic [31:0] dac_code, rd;
    logic [63:0] bv;
    int          nb, n_mismatch, total_checks;
    int          in_m [4];
    int          dac_m [4];
    integer      seed = 32'hA412;
    qdsc_top qdsc_top_i (.CLK_SYS(clk_sys), .RST_N(rst_n), .CS_N(cs_n),
        .SCLK(sclk), .SERIAL_IN(serial_in), .SDO(sdo), .SDO_OE(sdo_oe),
        .ASYNC_LOAD_N(async_load_n), .PWR_LOST(pwr_lost),
        .PFAIL_N(pfail_n), .DAC_CODE(dac_code));
    qdsc_host qdsc_host_i (.clk(clk_sys), .cs_n(cs_n), .sclk(sclk),
        .sdi(serial_in), .sdo(sdo), .sdo_oe(sdo_oe));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Append w bits, first sent first
    task automatic put(input int v, input int w);
        for (int i = 0; i < w; i++) bv[nb + i] = v[i];
        nb += w;
    endtask
    task automatic cmp_dac;
        for (int c = 0; c < 4; c++)
            chk("dac_code", dac_m[c], dac_code[8*c +: 8]);
    endtask
    // Write one channel or all; ch zeros lead the start bit
    task automatic wr(input int ch, input int ld, input int g);
        int v;
        nb = 0;
        put(0, ch);
        put(1 | g << 2 | ld << 3, 4);
        if (g == 0) put({ch[0], ch[1]}, 2);
        for (int c = 0; c < 4; c++)
            if (g != 0 || c == ch)
            begin
                v = $random(seed) & 32'hFF;
                put(v, 8);
                in_m[c] = v;
                if (ld != 0) dac_m[c] = v;
            end
        qdsc_host_i.frame(bv, nb, 0, 2, rd);
        cmp_dac();
    endtask
    task automatic rdb(input int g, input int e, input int m, input int a);
        logic [7:0] b;
        int         all;
        all = g != 0 && a == 2;
        nb = 0;
        put(3 | g << 2 | e << 3 | m << 4 | a[1] << 5 | a[0] << 6, 7);
        qdsc_host_i.frame(bv, nb, all ? 32 : 8, e, rd);
        for (int k = 0; k < (all ? 4 : 1); k++)
        begin
            for (int j = 0; j < 8; j++)
                b[m ? 7 - j : j] = rd[8*k + j];
            chk("readback", in_m[all ? k : a], b);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial
    begin
        #800000;
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        rst_n = 1'b0;
        pwr_lost = 1'b1;
        async_load_n = 1'b1;
        for (int c = 0; c < 4; c++) dac_m[c] = 0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("pfail_n", 0, pfail_n);
        chk("dac_code", 0, dac_code);
        for (int k = 0; k < 8; k++) wr(k % 4, k / 4, 0);
        chk("pfail_n", 1, pfail_n);
        $display("test single_write done");
        for (int k = 0; k < 20; k++)
            rdb(k >= 16, k % 2, k / 2 % 2, k >= 16 ? 2 : k / 4);
        rdb(1, 0, 1, 1);
        $display("test readback done");
        wr(3, 1, 1);
        rdb(1, 1, 0, 2);
        $display("test broadcast done");
        wr(0, 0, 1);
        @(posedge clk_sys);
        async_load_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        for (int c = 0; c < 4; c++) dac_m[c] = in_m[c];
        cmp_dac();
        async_load_n <= 1'b1;
        $display("test async_load done");
        end_of_test();
    end
endmodule
